/* File: dur_pkg.sv */
package dur_pkg;
  localparam int FRAME_W = 24;
  localparam int CH_N    = 4;
  localparam int CODE_W  = 10;
  localparam int CMD_HI  = 23;
  localparam int CMD_LO  = 20;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 16;
  localparam int DATA_HI = 15;
  localparam int DATA_LO = 6;
  localparam int MASK_HI = 3;
  localparam int MASK_LO = 0;
  localparam int REF_BIT = 0;

  typedef logic [3:0]        dur_cmd_t;
  typedef logic [CODE_W-1:0] dur_code_t;
  typedef logic [CH_N-1:0]   dur_chan_t;

  localparam dur_cmd_t  CMD_WRITE_IN  = 4'h1;
  localparam dur_cmd_t  CMD_UPDATE    = 4'h2;
  localparam dur_cmd_t  CMD_WRITE_UPD = 4'h3;
  localparam dur_cmd_t  CMD_MASK      = 4'h5;
  localparam dur_cmd_t  CMD_SOFT_RST  = 4'h6;
  localparam dur_cmd_t  CMD_REF       = 4'h7;

  localparam dur_code_t ZERO_SCALE    = 10'h000;
  localparam dur_code_t MID_SCALE     = 10'h200;
  localparam dur_chan_t MASK_RST      = 4'h0;
  localparam logic      REF_ON_RST    = 1'b1;
  localparam logic      TIED_LOW_RST  = 1'b1;
endpackage

/* File: dur_bank_if.sv */
`timescale 1ns/1ps
interface dur_bank_if;
  import dur_pkg::*;
  logic                         clear;
  dur_code_t                    clear_code;
  dur_chan_t                    in_we;
  dur_chan_t                    out_we;
  dur_chan_t                    copy;
  dur_code_t                    wdata;
  logic [CH_N-1:0][CODE_W-1:0]  in_codes;
  logic [CH_N-1:0][CODE_W-1:0]  out_codes;

  modport ctrl (
    output clear, clear_code, in_we, out_we, copy, wdata,
    input  in_codes, out_codes
  );
  modport bank (
    input  clear, clear_code, in_we, out_we, copy, wdata,
    output in_codes, out_codes
  );
endinterface

/* File: dur_edge.sv */
`timescale 1ns/1ps
module dur_edge #(
  parameter int              W    = 2,
  parameter logic [W-1:0]    INIT = '1
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          ce,
  // Sampled levels and their edges
  input  wire logic [W-1:0]  level,
  output logic [W-1:0]       rise,
  output logic [W-1:0]       fall
);
  logic [W-1:0] prev_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prev_ff <= INIT;
    else if (ce)
      prev_ff <= level;
  end

  // An edge only counts on an enabled cycle, so a frozen block never sees a stale edge twice.
  assign rise = ce ? (level & ~prev_ff) : '0;
  assign fall = ce ? (~level & prev_ff) : '0;
endmodule

/* File: dur_bank.sv */
`timescale 1ns/1ps
module dur_bank (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  ce,
  // Register bank port
  dur_bank_if.bank   bus
);
  import dur_pkg::*;

  for (genvar ch = 0; ch < CH_N; ch++)
  begin : g_ch
    dur_code_t in_ff;
    dur_code_t out_ff;

    always_ff @(posedge clock or negedge nrst)
    begin
      if (!nrst)
        in_ff <= ZERO_SCALE;
      else if (ce)
      begin
        if (bus.clear)
          in_ff <= bus.clear_code;
        else if (bus.in_we[ch])
          in_ff <= bus.wdata;
      end
    end

    // A direct write beats a copy, so a write-and-update never lands stale input data.
    always_ff @(posedge clock or negedge nrst)
    begin
      if (!nrst)
        out_ff <= ZERO_SCALE;
      else if (ce)
      begin
        if (bus.clear)
          out_ff <= bus.clear_code;
        else if (bus.out_we[ch])
          out_ff <= bus.wdata;
        else if (bus.copy[ch])
          out_ff <= in_ff;
      end
    end

    assign bus.in_codes[ch]  = in_ff;
    assign bus.out_codes[ch] = out_ff;
  end
endmodule

/* File: dur_ctrl.sv */
`timescale 1ns/1ps
// Operation
// R1 - Strobe high during input write defers output update to strobe falling edge.
// R2 - Mask command loads four mask bits from data bits 3..0, address ignored.
// R3 - Mask bits reset to zero; unmasked channels follow the hardware strobe.
// R4 - Masked channel ignores strobe transitions and sees the strobe as high.
// R5 - Input write always loads input register; output too only if strobe low.
// R6 - Update command copies selected input registers to outputs, strobe ignored.
// R7 - Write-and-update loads input and output registers, strobe ignored.
// R8 - Every strobe falling edge copies inputs to outputs on unmasked channels.
// R9 - With strobe permanently low, mask bits are ignored entirely.
// R10 - Hardware reset clears outputs to zero or midscale per select pin.
// R11 - Updates rejected while hardware reset low; cleared value held after.
// R12 - Software reset command returns device to its power-on state.
// R13 - Strobe activity ignored while power-on reset is in progress.
// R14 - Hardware reset low at power-up defers initialization until released.
// R15 - Power-up code is zero or midscale per select pin, held until written.
// R16 - Reference command bit 0: zero turns reference on, one off; on by default.
// R17 - Host sends 24-bit frames, latched on rising edge of frame sync.
module dur_ctrl (
  // Clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  nrst,
  input  wire logic                                  ce,
  // Frame port
  input  wire logic                                  sync_n,
  input  wire logic [dur_pkg::FRAME_W-1:0]           frame_word,
  // Pins
  input  wire logic                                  load_strobe_n,
  input  wire logic                                  hw_reset_n,
  input  wire logic                                  clear_level_select,
  // Outputs
  output logic [dur_pkg::CH_N-1:0][dur_pkg::CODE_W-1:0] output_codes,
  output logic                                       ref_on,
  output logic                                       init_busy
);
  import dur_pkg::*;

  typedef enum logic [1:0] {ST_WAIT_RST, ST_LOAD, ST_RUN} dur_state_e;

  dur_state_e state_ff;
  dur_state_e nxt_state;
  dur_chan_t  mask_ff;
  logic       ref_on_ff;
  logic       tied_low_ff;
  logic [1:0] rise;
  logic [1:0] fall;
  logic       sync_rise;
  logic       strobe_fall;
  logic       run;
  logic       take;
  dur_cmd_t   cmd;
  dur_chan_t  addr;
  dur_code_t  data;
  dur_chan_t  strobe_eff_low;

  dur_bank_if bus ();

  dur_edge #(
    .W    (2),
    .INIT (2'h3)
  ) u_edge (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .level ({load_strobe_n, sync_n}),
    .rise  (rise),
    .fall  (fall)
  );

  dur_bank u_bank (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .bus   (bus)
  );

  assign sync_rise   = rise[0];
  assign strobe_fall = fall[1];
  assign run         = (state_ff == ST_RUN);
  assign cmd         = frame_word[CMD_HI:CMD_LO];
  assign addr        = frame_word[ADDR_HI:ADDR_LO];
  assign data        = frame_word[DATA_HI:DATA_LO];

  // R17 frame latch edge
  // R11 reset rejects frames
  assign take = sync_rise & run & hw_reset_n;

  // R4 masked sees high
  // R9 tied low overrides
  assign strobe_eff_low = {CH_N{~load_strobe_n}} & (~mask_ff | {CH_N{tied_low_ff}});

  // R14 wait for release
  // R12 soft reset restart
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT_RST:
        if (hw_reset_n)
          nxt_state = ST_LOAD;
      ST_LOAD:
        nxt_state = ST_RUN;
      ST_RUN:
        if (take && cmd == CMD_SOFT_RST)
          nxt_state = ST_WAIT_RST;
      default:
        nxt_state = ST_WAIT_RST;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_ff <= ST_WAIT_RST;
    else if (ce)
      state_ff <= nxt_state;
  end

  // R2 mask load
  // R3 mask default zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      mask_ff <= MASK_RST;
    else if (ce)
    begin
      if (state_ff == ST_LOAD)
        mask_ff <= MASK_RST;
      else if (take && cmd == CMD_MASK)
        mask_ff <= frame_word[MASK_HI:MASK_LO];
    end
  end

  // R16 reference setup
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ref_on_ff <= REF_ON_RST;
    else if (ce)
    begin
      if (state_ff == ST_LOAD)
        ref_on_ff <= REF_ON_RST;
      else if (take && cmd == CMD_REF)
        ref_on_ff <= ~frame_word[REF_BIT];
    end
  end

  // R9 permanent low tracking
  // A single high sample is taken as proof that the strobe is not tied low.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      tied_low_ff <= TIED_LOW_RST;
    else if (ce && load_strobe_n)
      tied_low_ff <= 1'b0;
  end

  always_comb
  begin
    // R10 hardware reset clear
    // R15 power-up clear code
    bus.clear      = ~hw_reset_n | (state_ff == ST_LOAD);
    bus.clear_code = clear_level_select ? MID_SCALE : ZERO_SCALE;
    bus.wdata      = data;
    bus.in_we      = '0;
    bus.out_we     = '0;
    bus.copy       = '0;
    // R11 no updates in reset
    // R13 strobe ignored at init
    if (run && hw_reset_n)
    begin
      // R8 strobe falling edge
      // R1 deferred update
      if (strobe_fall)
        bus.copy = ~mask_ff;
      if (take)
      begin
        case (cmd)
          // R5 input write
          CMD_WRITE_IN:
          begin
            bus.in_we  = addr;
            bus.out_we = addr & strobe_eff_low;
          end
          // R6 update command
          CMD_UPDATE:
            bus.copy = bus.copy | addr;
          // R7 write and update
          CMD_WRITE_UPD:
          begin
            bus.in_we  = addr;
            bus.out_we = addr;
          end
          default:
            bus.in_we = '0;
        endcase
      end
    end
  end

  assign output_codes = bus.out_codes;
  assign ref_on       = ref_on_ff;
  assign init_busy    = ~run;

  a_mask_load: assert property (@(posedge clock) disable iff (!nrst) // R2
    ce && take && cmd == CMD_MASK |=> mask_ff == $past(frame_word[MASK_HI:MASK_LO]))
    else $error("Mask not loaded from frame.");

  a_mask_default: assert property (@(posedge clock) disable iff (!nrst) // R3
    ce && state_ff == ST_LOAD |=> mask_ff == MASK_RST && ref_on_ff)
    else $error("Mask or reference not at default after init.");

  a_masked_ignore: assert property (@(posedge clock) disable iff (!nrst) // R4
    mask_ff[0] && !tied_low_ff && !(take && cmd == CMD_UPDATE) |-> !bus.copy[0])
    else $error("Masked channel followed the strobe.");

  a_input_write: assert property (@(posedge clock) disable iff (!nrst) // R5
    ce && take && cmd == CMD_WRITE_IN && addr[0] && load_strobe_n
    |=> bus.in_codes[0] == $past(data) && $stable(bus.out_codes[0]))
    else $error("Input write with strobe high misbehaved.");

  a_update_copy: assert property (@(posedge clock) disable iff (!nrst) // R6
    ce && take && cmd == CMD_UPDATE && addr[1]
    |=> bus.out_codes[1] == $past(bus.in_codes[1]) && $stable(bus.in_codes))
    else $error("Update command did not copy input to output.");

  a_write_update: assert property (@(posedge clock) disable iff (!nrst) // R7
    ce && take && cmd == CMD_WRITE_UPD && addr[2]
    |=> bus.out_codes[2] == $past(data) && bus.in_codes[2] == $past(data))
    else $error("Write-and-update did not load both registers.");

  sequence s_strobe_fall_unmasked;
    ce && run && hw_reset_n && strobe_fall && !mask_ff[3] && !bus.out_we[3];
  endsequence

  a_strobe_update: assert property (@(posedge clock) disable iff (!nrst) // R8
    s_strobe_fall_unmasked |=> bus.out_codes[3] == $past(bus.in_codes[3]))
    else $error("Strobe falling edge did not update output.");

  a_hw_reset: assert property (@(posedge clock) disable iff (!nrst) // R10
    ce && !hw_reset_n
    |=> bus.out_codes[0] == ($past(clear_level_select) ? MID_SCALE : ZERO_SCALE))
    else $error("Hardware reset did not clear output.");

  sequence s_reset_held;
    ce && !hw_reset_n ##1 ce && !hw_reset_n;
  endsequence

  a_reset_hold: assert property (@(posedge clock) disable iff (!nrst) // R11
    s_reset_held ##0 $stable(clear_level_select) |=> $stable(bus.out_codes))
    else $error("Output changed while hardware reset held.");

  a_init_quiet: assert property (@(posedge clock) disable iff (!nrst) // R13
    !run |-> bus.copy == '0 && bus.out_we == '0 && bus.in_we == '0)
    else $error("Update during power-on reset.");

  a_init_defer: assert property (@(posedge clock) disable iff (!nrst) // R14
    ce && state_ff == ST_WAIT_RST && !hw_reset_n |=> state_ff == ST_WAIT_RST)
    else $error("Init completed while hardware reset low.");

  a_ref_setup: assert property (@(posedge clock) disable iff (!nrst) // R16
    ce && take && cmd == CMD_REF |=> ref_on_ff == !$past(frame_word[REF_BIT]))
    else $error("Reference state not set from frame.");

  sequence s_write_strobe_high;
    ce && take && cmd == CMD_WRITE_IN && load_strobe_n;
  endsequence

  a_deferred_hold: assert property (@(posedge clock) disable iff (!nrst) // R1
    s_write_strobe_high |=> $stable(bus.out_codes))
    else $error("Output moved before the strobe fell.");

  a_mask_free_copy: assert property (@(posedge clock) disable iff (!nrst) // R3
    run && hw_reset_n && strobe_fall && !mask_ff[2] |-> bus.copy[2])
    else $error("Unmasked channel missed the strobe.");

  a_tied_low_direct: assert property (@(posedge clock) disable iff (!nrst) // R9
    ce && take && cmd == CMD_WRITE_IN && tied_low_ff && !load_strobe_n && addr[2]
    |=> bus.out_codes[2] == $past(data))
    else $error("Tied-low strobe did not write through.");

  a_tied_low_stick: assert property (@(posedge clock) disable iff (!nrst) // R9
    ce && load_strobe_n |=> !tied_low_ff)
    else $error("High strobe sample not recorded.");

  a_hw_reject: assert property (@(posedge clock) disable iff (!nrst) // R11
    !hw_reset_n |-> bus.in_we == '0 && bus.out_we == '0 && bus.copy == '0)
    else $error("Update accepted during hardware reset.");

  a_soft_reset: assert property (@(posedge clock) disable iff (!nrst) // R12
    ce && take && cmd == CMD_SOFT_RST |=> state_ff == ST_WAIT_RST)
    else $error("Software reset did not restart.");

  a_powerup_code: assert property (@(posedge clock) disable iff (!nrst) // R15
    ce && state_ff == ST_LOAD
    |=> bus.out_codes[1] == ($past(clear_level_select) ? MID_SCALE : ZERO_SCALE))
    else $error("Power-up code does not follow the select pin.");

  a_frame_edge: assert property (@(posedge clock) disable iff (!nrst) // R17
    ce && $past(ce) && sync_n && !$past(sync_n) && run && hw_reset_n |-> take)
    else $error("Frame sync rise not latched.");
endmodule

/* File: dur_host.sv */
`timescale 1ns/1ps
module dur_host (
  // Clock
  input  wire logic                        clock,
  // Frame port
  output logic                             sync_n,
  output logic [dur_pkg::FRAME_W-1:0]      frame_word
);
  import dur_pkg::*;

  initial
  begin
    sync_n     = 1'b1;
    frame_word = '0;
  end

  task automatic send(input dur_cmd_t cmd, input dur_chan_t sel, input logic [15:0] dat);
    logic [FRAME_W-1:0] f;
    f = {cmd, sel, dat};
    @(posedge clock);
    sync_n     <= 1'b0;
    frame_word <= ~f;
    @(posedge clock);
    sync_n     <= 1'b1;
    frame_word <= f;
    @(posedge clock);
    // The word is scrambled one clock after sync rises, so a late sample cannot match by luck.
    frame_word <= ~f;
    repeat (2) @(posedge clock);
  endtask
endmodule

/* File: dur_ctrl_tb.sv */
`timescale 1ns/1ps
module dur_ctrl_tb;
  import dur_pkg::*;
  logic                             clock;
  logic                             nrst;
  logic                             ce;
  logic                             sync_n;
  logic [FRAME_W-1:0]               frame_word;
  logic                             load_strobe_n;
  logic                             hw_reset_n;
  logic                             clear_level_select;
  logic [CH_N-1:0][CODE_W-1:0]      output_codes;
  logic                             ref_on;
  logic                             init_busy;
  int                               n_fail;
  int                               total_checks;
  int                               cycles;

  dur_host host_u (.clock(clock), .sync_n(sync_n), .frame_word(frame_word));

  dur_ctrl dut_u (
    .clock(clock), .nrst(nrst), .ce(ce), .sync_n(sync_n), .frame_word(frame_word),
    .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
    .clear_level_select(clear_level_select), .output_codes(output_codes),
    .ref_on(ref_on), .init_busy(init_busy)
  );

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk_code(input string name, input dur_code_t exp, input dur_code_t got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input dur_cmd_t cmd, input int ch, input dur_code_t code);
    host_u.send(cmd, dur_chan_t'(1 << ch), {code, 6'h00});
  endtask

  task automatic pulse;
    @(posedge clock);
    load_strobe_n <= 1'b0;
    repeat (3) @(posedge clock);
    load_strobe_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  // Bounded wait, since a stuck start-up must not hang the run.
  task automatic wait_ready;
    for (int i = 0; i < 20 && init_busy !== 1'b0; i++)
      @(posedge clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    load_strobe_n = 1'b1;
    hw_reset_n = 1'b1;
    clear_level_select = 1'b0;
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    wait_ready();
    chk_bit("busy", 1'b0, init_busy);
    for (int i = 0; i < CH_N; i++)
      chk_code("power_up", ZERO_SCALE, output_codes[i]);
    chk_bit("ref_on", 1'b1, ref_on);
    $display("test power_up done");
    wr(CMD_WRITE_UPD, 0, 10'h155);
    chk_code("out0", 10'h155, output_codes[0]);
    wr(CMD_WRITE_IN, 1, 10'h0aa);
    chk_code("out1", ZERO_SCALE, output_codes[1]);
    pulse();
    chk_code("out1", 10'h0aa, output_codes[1]);
    chk_code("out0", 10'h155, output_codes[0]);
    $display("test deferred done");
    host_u.send(CMD_MASK, 4'hf, 16'h0002);
    wr(CMD_WRITE_IN, 1, 10'h111);
    wr(CMD_WRITE_IN, 2, 10'h222);
    pulse();
    chk_code("out1", 10'h0aa, output_codes[1]);
    chk_code("out2", 10'h222, output_codes[2]);
    wr(CMD_UPDATE, 1, 10'h3ff);
    chk_code("out1", 10'h111, output_codes[1]);
    $display("test mask done");
    host_u.send(CMD_MASK, 4'h0, 16'h0000);
    load_strobe_n <= 1'b0;
    wr(CMD_WRITE_IN, 3, 10'h0f0);
    chk_code("out3", 10'h0f0, output_codes[3]);
    chk_code("out2", 10'h222, output_codes[2]);
    load_strobe_n <= 1'b1;
    host_u.send(CMD_REF, 4'h0, 16'h0001);
    chk_bit("ref_on", 1'b0, ref_on);
    host_u.send(CMD_REF, 4'h0, 16'h0000);
    chk_bit("ref_on", 1'b1, ref_on);
    $display("test direct and ref done");
    ce <= 1'b0;
    wr(CMD_WRITE_UPD, 2, 10'h3c3);
    chk_code("frozen", 10'h222, output_codes[2]);
    ce <= 1'b1;
    wr(CMD_WRITE_UPD, 2, 10'h2d2);
    chk_code("out2", 10'h2d2, output_codes[2]);
    $display("test freeze done");
    clear_level_select <= 1'b1;
    hw_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < CH_N; i++)
      chk_code("hw_clear", MID_SCALE, output_codes[i]);
    wr(CMD_WRITE_UPD, 0, 10'h055);
    pulse();
    chk_code("out0", MID_SCALE, output_codes[0]);
    hw_reset_n <= 1'b1;
    pulse();
    chk_code("out0", MID_SCALE, output_codes[0]);
    $display("test hw_reset done");
    host_u.send(CMD_MASK, 4'h0, 16'h0001);
    host_u.send(CMD_REF, 4'h0, 16'h0001);
    clear_level_select <= 1'b0;
    host_u.send(CMD_SOFT_RST, 4'h0, 16'h0000);
    wait_ready();
    chk_code("out1", ZERO_SCALE, output_codes[1]);
    chk_bit("ref_on", 1'b1, ref_on);
    wr(CMD_WRITE_IN, 0, 10'h077);
    pulse();
    chk_code("out0", 10'h077, output_codes[0]);
    $display("test soft_reset done");
    load_strobe_n <= 1'b0;
    hw_reset_n <= 1'b0;
    clear_level_select <= 1'b1;
    nrst <= 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    chk_bit("busy", 1'b1, init_busy);
    hw_reset_n <= 1'b1;
    wait_ready();
    chk_bit("busy", 1'b0, init_busy);
    chk_code("power_up", MID_SCALE, output_codes[0]);
    host_u.send(CMD_MASK, 4'h0, 16'h000f);
    wr(CMD_WRITE_IN, 2, 10'h1c3);
    chk_code("out2", 10'h1c3, output_codes[2]);
    $display("test tied_low done");
    wrap_up();
  end
endmodule
